// ===== src/ufa_ctl.sv
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ufa_ctl
	import ufa_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	ufa_if.ctl port,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	typedef enum logic [3:0] {
		S_IDLE, S_PRE, S_REQ, S_WAIT, S_POLL, S_POLLW, S_PCHK, S_XFER,
		S_XFERW, S_XCHK, S_GAP, S_END1, S_END2, S_CLR, S_ZRD
	} ufa_state_e;
	typedef struct packed {
		ufa_state_e st;
		logic dir;
		logic pipe;
		logic keepSetup;
		logic [3:0] len;
		logic [3:0] cnt;
		logic [8:0] waitCnt;
		logic [7:0][7:0] txBuf;
		logic [7:0][7:0] rxBuf;
		logic busy;
		logic done;
		logic zlf;
		logic setup;
		logic lastPipe;
		logic [7:0] regAddr;
		logic [7:0] regWdata;
		logic regWr;
		logic regRd;
		logic awHeld;
		logic wHeld;
		logic [7:0] awAddr;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ufa_ctl_s;
	ufa_ctl_s cReg;
	ufa_ctl_s cNext;

	function automatic logic [7:0] cmdByte(input logic keep,
		input logic pipe, input logic clr, input logic tx, input logic req);
		cmdByte = {2'b00, keep, 1'b0, pipe, clr, tx, req};
	endfunction : cmdByte

	function automatic logic [7:0] epAddr(input logic pipe);
		epAddr = pipe ? EP1_ADDR : EP0_ADDR;
	endfunction : epAddr

	assign awready = !cReg.awHeld && !cReg.bvalid;
	assign wready = !cReg.wHeld && !cReg.bvalid;
	assign arready = !cReg.rvalid;

	always_comb
	begin
		cNext = cReg;
		cNext.regWr = 1'b0;
		cNext.regRd = 1'b0;
		if (awvalid && awready)
		begin
			cNext.awHeld = 1'b1;
			cNext.awAddr = awaddr;
		end
		if (wvalid && wready)
		begin
			cNext.wHeld = 1'b1;
			cNext.wData = wdata;
			cNext.wStrb = wstrb;
		end
		if (bvalid && bready)
			cNext.bvalid = 1'b0;
		if (rvalid && rready)
			cNext.rvalid = 1'b0;
		if (port.usbInt)
			cNext.lastPipe = port.activePipe;
		case (cReg.st)
			S_IDLE:
			begin
				cNext.busy = 1'b0;
				if (cReg.awHeld && cReg.wHeld && cReg.awAddr == AX_CTRL
					&& cReg.wStrb[0] && cReg.wData[0])
				begin
					cNext.busy = 1'b1;
					cNext.done = 1'b0;
					cNext.dir = cReg.wData[1];
					cNext.pipe = cReg.wData[2];
					cNext.keepSetup = !cReg.wData[4];
					cNext.len = (cReg.wData[11:8] > PKT_MAX) ? PKT_MAX
						: cReg.wData[11:8];
					cNext.cnt = 4'h0;
					cNext.regWr = 1'b1;
					cNext.regAddr = CMD_ADDR;
					cNext.regWdata = cmdByte(!cReg.wData[4], cReg.wData[2],
						cReg.wData[3], cReg.wData[1], 1'b0);
					cNext.st = cReg.wData[3] ? S_CLR : S_REQ;
				end
			end
			S_CLR:
			begin
				cNext.regWr = 1'b1;
				cNext.regWdata = cmdByte(cReg.keepSetup, cReg.pipe, 1'b0,
					1'b0, 1'b0);
				cNext.done = 1'b1;
				cNext.st = S_IDLE;
			end
			S_REQ:
			begin
				cNext.regWr = 1'b1;
				cNext.regWdata = cmdByte(cReg.keepSetup, cReg.pipe, 1'b0,
					cReg.dir, 1'b1);
				cNext.waitCnt = GAP_CNT;
				cNext.st = S_WAIT;
			end
			S_WAIT, S_GAP:
			begin
				cNext.waitCnt = cReg.waitCnt - 9'h001;
				if (cReg.waitCnt == 9'h001)
					cNext.st = S_POLL;
			end
			S_POLL:
			begin
				cNext.regRd = 1'b1;
				cNext.regAddr = CMD_ADDR;
				cNext.st = S_POLLW;
			end
			S_POLLW:
				cNext.st = S_PCHK;
			S_PCHK:
			begin
				cNext.zlf = port.regRdata[BIT_ZLF];
				cNext.setup = port.regRdata[BIT_SETUP];
				if (port.regRdata[BIT_READY])
					cNext.st = (cReg.dir && cReg.cnt == cReg.len)
						? S_END1 : S_XFER;
				else if (cReg.cnt != 4'h0)
					cNext.st = S_END1;
				// An empty packet is acknowledged by one data read
				else if (!cReg.dir && port.regRdata[BIT_ZLF])
					cNext.st = S_ZRD;
				else
					cNext.st = S_POLL;
			end
			S_XFER:
			begin
				cNext.regAddr = epAddr(cReg.pipe);
				if (cReg.dir)
				begin
					cNext.regWr = 1'b1;
					cNext.regWdata = cReg.txBuf[cReg.cnt[2:0]];
					cNext.cnt = cReg.cnt + 4'h1;
					cNext.waitCnt = GAP_CNT;
					cNext.st = S_GAP;
				end
				else
				begin
					cNext.regRd = 1'b1;
					cNext.st = S_XFERW;
				end
			end
			S_XFERW:
				cNext.st = S_XCHK;
			S_XCHK:
			begin
				cNext.rxBuf[cReg.cnt[2:0]] = port.regRdata;
				cNext.cnt = cReg.cnt + 4'h1;
				cNext.waitCnt = GAP_CNT;
				cNext.st = S_GAP;
			end
			S_END1:
			begin
				cNext.regWr = 1'b1;
				cNext.regAddr = CMD_ADDR;
				cNext.regWdata = cmdByte(cReg.keepSetup, cReg.pipe, 1'b0,
					!cReg.dir, 1'b1);
				cNext.st = S_END2;
			end
			S_END2:
			begin
				cNext.regWr = 1'b1;
				cNext.regWdata = cmdByte(cReg.keepSetup, cReg.pipe, 1'b0,
					!cReg.dir, 1'b0);
				cNext.done = 1'b1;
				cNext.st = S_IDLE;
			end
			S_ZRD:
			begin
				cNext.regRd = 1'b1;
				cNext.regAddr = epAddr(cReg.pipe);
				cNext.st = S_END1;
			end
			default:
				cNext.st = S_IDLE;
		endcase
		if (cReg.awHeld && cReg.wHeld)
		begin
			cNext.awHeld = 1'b0;
			cNext.wHeld = 1'b0;
			cNext.bvalid = 1'b1;
			cNext.bresp = RESP_OKAY;
			for (int b = 0; b < 4; b++)
			begin
				if (cReg.wStrb[b] && cReg.awAddr == AX_TXLO)
					cNext.txBuf[b] = cReg.wData[8*b +: 8];
				if (cReg.wStrb[b] && cReg.awAddr == AX_TXHI)
					cNext.txBuf[b+4] = cReg.wData[8*b +: 8];
			end
			if (cReg.awAddr != AX_CTRL && cReg.awAddr != AX_TXLO
				&& cReg.awAddr != AX_TXHI)
				cNext.bresp = RESP_SLVERR;
		end
		if (arvalid && arready)
		begin
			cNext.rvalid = 1'b1;
			cNext.rresp = RESP_OKAY;
			case (araddr)
				AX_CTRL: cNext.rdata = {20'h00000, cReg.len, 5'h00,
					cReg.pipe, cReg.dir, 1'b0};
				AX_STAT: cNext.rdata = {23'h000000, cReg.lastPipe,
					cReg.cnt, cReg.zlf, cReg.setup, cReg.done, cReg.busy};
				AX_TXLO: cNext.rdata = cReg.txBuf[3:0];
				AX_TXHI: cNext.rdata = cReg.txBuf[7:4];
				AX_RXLO: cNext.rdata = cReg.rxBuf[3:0];
				AX_RXHI: cNext.rdata = cReg.rxBuf[7:4];
				default:
				begin
					cNext.rdata = 32'h00000000;
					cNext.rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			cReg <= '0;
			cReg.st <= S_IDLE;
		end
		else
			cReg <= cNext;
	end

	assign port.regAddr = cReg.regAddr;
	assign port.regWdata = cReg.regWdata;
	assign port.regWr = cReg.regWr;
	assign port.regRd = cReg.regRd;
	assign bvalid = cReg.bvalid;
	assign bresp = cReg.bresp;
	assign rvalid = cReg.rvalid;
	assign rdata = cReg.rdata;
	assign rresp = cReg.rresp;
endmodule : ufa_ctl
`default_nettype wire

// ===== src/ufa_pkg.sv
// How it works
// - Access granted only while request bit high
// - Direction one writes buffer, zero reads it
// - After write, direction to zero, then drop
// - After read, direction to one, then drop
// - Clear empties selected buffer even unready
// - Select 00 is endpoint 0, 01 endpoint 1
// - Setup flag set by engine, cleared by firmware
// - Ready shows selected buffer can take access
// - Zero-length packet from host sets flag
// - Data register read clears zero-length flag
// - Next setup token clears zero-length flag
// - Two eight-byte buffers behind pointer ports
// - Eight bytes maximum, firmware counts bytes
// - Read ends when ready drops, no bytes left
// - Write ends when ready drops, buffer full; the controller stops once the set length is written
// - Wait two microseconds before sampling ready
// - Two microseconds between consecutive byte moves
// - Zero-length send: request, ready, toggle, drop
// - Host-busy pipe is not granted to processor
// - Host done raises interrupt with pipe number
package ufa_pkg;
	localparam logic [7:0] CMD_ADDR = 8'h46;
	localparam logic [7:0] EP0_ADDR = 8'h48;
	localparam logic [7:0] EP1_ADDR = 8'h49;
	localparam int BIT_REQ = 0;
	localparam int BIT_TX = 1;
	localparam int BIT_CLR = 2;
	localparam int BIT_SEL_LO = 3;
	localparam int BIT_SEL_HI = 4;
	localparam int BIT_SETUP = 5;
	localparam int BIT_READY = 6;
	localparam int BIT_ZLF = 7;
	localparam logic [1:0] SEL_EP0 = 2'h0;
	localparam logic [1:0] SEL_EP1 = 2'h1;
	localparam int BUF_DEPTH = 8;
	localparam logic [3:0] PKT_MAX = 4'h8;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam int CLK_NS = 5;
	localparam int GAP_NS = 2000;
	localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [8:0] GAP_CNT = 9'(GAP_CYC);
	localparam logic [7:0] AX_CTRL = 8'h00;
	localparam logic [7:0] AX_STAT = 8'h04;
	localparam logic [7:0] AX_TXLO = 8'h08;
	localparam logic [7:0] AX_TXHI = 8'h0C;
	localparam logic [7:0] AX_RXLO = 8'h10;
	localparam logic [7:0] AX_RXHI = 8'h14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ufa_pkg

// ===== src/ufa_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ufa_if;
	logic [7:0] regAddr;
	logic [7:0] regWdata;
	logic [7:0] regRdata;
	logic regWr;
	logic regRd;
	logic usbInt;
	logic activePipe;
	modport dev (input regAddr, regWdata, regWr, regRd,
		output regRdata, usbInt, activePipe);
	modport ctl (output regAddr, regWdata, regWr, regRd,
		input regRdata, usbInt, activePipe);
endinterface : ufa_if
`default_nettype wire

// ===== src/ufa_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module ufa_buffer
	import ufa_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic wrEn,
	input wire logic [2:0] wrIdx,
	input wire logic [7:0] wrData,
	input wire logic [2:0] rdIdxA,
	input wire logic [2:0] rdIdxB,
	output logic [7:0] rdDataA,
	output logic [7:0] rdDataB
);
	typedef struct packed {
		logic [BUF_DEPTH-1:0][7:0] mem;
	} ufa_buf_s;
	ufa_buf_s bufReg;
	ufa_buf_s bufNext;

	always_comb
	begin
		bufNext = bufReg;
		for (int i = 0; i < BUF_DEPTH; i++)
		begin
			if (wrEn && wrIdx == 3'(i))
				bufNext.mem[i] = wrData;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			bufReg <= '0;
		else
			bufReg <= bufNext;
	end

	assign rdDataA = bufReg.mem[rdIdxA];
	assign rdDataB = bufReg.mem[rdIdxB];
endmodule : ufa_buffer
`default_nettype wire

// ===== src/ufa_device.sv
`timescale 1ns/1ps
`default_nettype none
module ufa_device
	import ufa_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	ufa_if.dev port,
	input wire logic [1:0] engineBusy,
	input wire logic rxByteValid,
	input wire logic rxPipe,
	input wire logic [7:0] rxByte,
	input wire logic rxEnd,
	input wire logic rxSetup,
	input wire logic setupToken,
	input wire logic txRd,
	input wire logic txDone,
	input wire logic txPipe,
	output logic [1:0] txPending,
	output logic [1:0][3:0] txLen,
	output logic [7:0] txData,
	output logic txLast
);
	typedef struct packed {
		logic req;
		logic tx;
		logic clr;
		logic [1:0] sel;
		logic setup;
		logic zlf;
		logic zlfPipe;
		logic started;
		logic accDir;
		logic accPipe;
		logic [1:0][3:0] len;
		logic [1:0][3:0] ptr;
		logic [1:0] rxFull;
		logic [1:0] txFull;
		logic [3:0] hptr;
		logic [7:0] rdata;
		logic usbInt;
		logic actPipe;
		logic [7:0] txData;
		logic txLast;
	} ufa_dev_s;
	ufa_dev_s stReg;
	ufa_dev_s stNext;

	logic [1:0] wrEn;
	logic [1:0][2:0] wrIdx;
	logic [1:0][7:0] wrData;
	logic [1:0][7:0] rdA;
	logic [1:0][7:0] rdB;
	logic sp;
	logic selOk;
	logic ready;
	logic ap;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : gBuf
			ufa_buffer uBuf (
				.clk_sys(clk_sys),
				.srst(srst),
				.wrEn(wrEn[g]),
				.wrIdx(wrIdx[g]),
				.wrData(wrData[g]),
				.rdIdxA(stReg.ptr[g][2:0]),
				.rdIdxB(stReg.hptr[2:0]),
				.rdDataA(rdA[g]),
				.rdDataB(rdB[g])
			);
		end
	endgenerate

	assign sp = stReg.sel[0];
	assign selOk = (stReg.sel == SEL_EP0) || (stReg.sel == SEL_EP1);
	// Ready only inside a granted access to an idle pipe
	always_comb
	begin
		ready = 1'b0;
		if (stReg.req && stReg.started && selOk && !engineBusy[sp])
		begin
			if (stReg.tx)
				ready = !stReg.txFull[sp] && !stReg.rxFull[sp]
					&& stReg.ptr[sp] < PKT_MAX;
			else
				ready = stReg.rxFull[sp]
					&& stReg.ptr[sp] < stReg.len[sp];
		end
	end

	always_comb
	begin
		ap = port.regAddr[0];
		stNext = stReg;
		stNext.usbInt = 1'b0;
		wrEn = '0;
		wrIdx = '0;
		wrData = '0;
		// Grant waits until the host leaves the pipe
		if (stReg.req && !stReg.started && selOk && !engineBusy[sp])
		begin
			stNext.started = 1'b1;
			stNext.accDir = stReg.tx;
			stNext.accPipe = sp;
			stNext.ptr[sp] = 4'h0;
		end
		// Dropping request ends the access; a toggled direction commits the buffer
		if (!stReg.req && stReg.started)
		begin
			stNext.started = 1'b0;
			if (stReg.accDir && !stReg.tx)
			begin
				stNext.txFull[stReg.accPipe] = 1'b1;
				stNext.len[stReg.accPipe] = stReg.ptr[stReg.accPipe];
			end
			if (!stReg.accDir && stReg.tx)
			begin
				stNext.rxFull[stReg.accPipe] = 1'b0;
				stNext.len[stReg.accPipe] = 4'h0;
			end
		end
		if (port.regWr && port.regAddr == CMD_ADDR)
		begin
			stNext.req = port.regWdata[BIT_REQ];
			stNext.tx = port.regWdata[BIT_TX];
			stNext.clr = port.regWdata[BIT_CLR];
			stNext.sel = port.regWdata[BIT_SEL_HI:BIT_SEL_LO];
			if (!port.regWdata[BIT_SETUP])
				stNext.setup = 1'b0;
			if (port.regWdata[BIT_CLR] && !port.regWdata[BIT_SEL_HI])
			begin
				stNext.len[port.regWdata[BIT_SEL_LO]] = 4'h0;
				stNext.ptr[port.regWdata[BIT_SEL_LO]] = 4'h0;
				stNext.rxFull[port.regWdata[BIT_SEL_LO]] = 1'b0;
				stNext.txFull[port.regWdata[BIT_SEL_LO]] = 1'b0;
			end
		end
		if (port.regWr && (port.regAddr == EP0_ADDR
			|| port.regAddr == EP1_ADDR))
		begin
			if (ready && stReg.tx && ap == sp)
			begin
				wrEn[ap] = 1'b1;
				wrIdx[ap] = stReg.ptr[ap][2:0];
				wrData[ap] = port.regWdata;
				stNext.ptr[ap] = stReg.ptr[ap] + 4'h1;
			end
		end
		if (port.regRd)
		begin
			stNext.rdata = BYTE_RESET;
			if (port.regAddr == CMD_ADDR)
				stNext.rdata = {stReg.zlf, ready, stReg.setup, stReg.sel,
					stReg.clr, stReg.tx, stReg.req};
			if (port.regAddr == EP0_ADDR || port.regAddr == EP1_ADDR)
			begin
				stNext.rdata = rdA[ap];
				if (ready && !stReg.tx && ap == sp)
					stNext.ptr[ap] = stReg.ptr[ap] + 4'h1;
				if (stReg.zlfPipe == ap)
					stNext.zlf = 1'b0;
			end
		end
		if (setupToken)
			stNext.zlf = 1'b0;
		// Engine events come last so they win over firmware updates in the same cycle
		if (rxByteValid && !stReg.rxFull[rxPipe] && !stReg.txFull[rxPipe]
			&& stReg.len[rxPipe] < PKT_MAX)
		begin
			wrEn[rxPipe] = 1'b1;
			wrIdx[rxPipe] = stReg.len[rxPipe][2:0];
			wrData[rxPipe] = rxByte;
			stNext.len[rxPipe] = stReg.len[rxPipe] + 4'h1;
		end
		if (rxEnd)
		begin
			if (stReg.len[rxPipe] != 4'h0)
				stNext.rxFull[rxPipe] = 1'b1;
			else
			begin
				stNext.zlf = 1'b1;
				stNext.zlfPipe = rxPipe;
			end
			if (rxSetup)
				stNext.setup = 1'b1;
			stNext.usbInt = 1'b1;
			stNext.actPipe = rxPipe;
		end
		if (txRd && stReg.txFull[txPipe])
		begin
			stNext.txData = rdB[txPipe];
			stNext.txLast = (stReg.hptr + 4'h1) >= stReg.len[txPipe];
			stNext.hptr = stReg.hptr + 4'h1;
		end
		if (txDone)
		begin
			stNext.txFull[txPipe] = 1'b0;
			stNext.len[txPipe] = 4'h0;
			stNext.hptr = 4'h0;
			stNext.usbInt = 1'b1;
			stNext.actPipe = txPipe;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			stReg <= '0;
		else
			stReg <= stNext;
	end

	assign port.regRdata = stReg.rdata;
	assign port.usbInt = stReg.usbInt;
	assign port.activePipe = stReg.actPipe;
	assign txPending = stReg.txFull;
	assign txLen = stReg.len;
	assign txData = stReg.txData;
	assign txLast = stReg.txLast;
endmodule : ufa_device
`default_nettype wire

// ===== test/ufa_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ufa_chk
	import ufa_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic usbInt,
	input wire logic activePipe
);
	localparam int GAP_MIN = GAP_CYC - 2;
	logic [7:0] cmdReg;
	logic accTx;
	logic [9:0] sinceReq;
	logic [9:0] sinceData;
	logic [3:0] nData;
	logic cmdWr;
	logic dataAcc;
	logic reqRise;
	assign cmdWr = regWr && regAddr == CMD_ADDR;
	assign dataAcc = (regWr || regRd) && regAddr[7:1] == EP0_ADDR[7:1];
	assign reqRise = cmdWr && regWdata[0] && !cmdReg[0];
	// Tracks the command byte, the access direction and the spacing
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			cmdReg <= 8'h00;
			accTx <= 1'b0;
			sinceReq <= 10'h000;
			sinceData <= 10'h3FF;
			nData <= 4'h0;
		end
		else
		begin
			if (cmdWr)
				cmdReg <= regWdata;
			if (reqRise)
				accTx <= regWdata[1];
			if (reqRise)
				sinceReq <= 10'h000;
			else if (sinceReq != 10'h3FF)
				sinceReq <= sinceReq + 10'h001;
			if (dataAcc)
				sinceData <= 10'h000;
			else if (sinceData != 10'h3FF)
				sinceData <= sinceData + 10'h001;
			if (reqRise)
				nData <= 4'h0;
			else if (dataAcc && nData != 4'hF)
				nData <= nData + 4'h1;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	property p_grant; dataAcc |-> cmdReg[0]; endproperty
	property p_dir; dataAcc |-> regWr == accTx; endproperty
	property p_toggle;
		cmdWr && !regWdata[0] && cmdReg[0] |-> cmdReg[1] != accTx;
	endproperty
	property p_select; dataAcc |-> cmdReg[4:3] == {1'b0, regAddr[0]}; endproperty
	property p_count; dataAcc |-> nData < 4'h8; endproperty
	property p_wait;
		regRd && regAddr == CMD_ADDR && cmdReg[0] |-> sinceReq >= GAP_MIN;
	endproperty
	property p_gap; dataAcc |-> sinceData >= GAP_MIN; endproperty
	property p_hold; !regRd |=> $stable(regRdata); endproperty
	property p_pipe; $changed(activePipe) |-> usbInt; endproperty
	property p_pulse; usbInt |=> !usbInt; endproperty
	a_grant: assert property (p_grant)
		else $error("data access without request");
	a_dir: assert property (p_dir)
		else $error("data access against direction");
	a_toggle: assert property (p_toggle)
		else $error("request dropped without direction toggle");
	a_select: assert property (p_select)
		else $error("data access to unselected buffer");
	a_count: assert property (p_count)
		else $error("more than eight bytes in one access");
	a_wait: assert property (p_wait)
		else $error("ready polled too early");
	a_gap: assert property (p_gap)
		else $error("byte accesses too close");
	a_hold: assert property (p_hold)
		else $error("read data moved without read");
	a_pipe: assert property (p_pipe)
		else $error("pipe number moved without interrupt");
	a_pulse: assert property (p_pulse)
		else $error("interrupt longer than one cycle");
	c_req: cover property (reqRise);
	c_wr: cover property (dataAcc && regWr);
	c_rd: cover property (dataAcc && regRd);
	c_int: cover property (usbInt && activePipe);
endmodule : ufa_chk
`default_nettype wire

// ===== test/usb_endpoint_fifo_access_tb.sv
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_fifo_access_tb;
	import ufa_pkg::*;
	logic clk_sys, srst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, txLast;
	logic rxByteValid, rxPipe, rxEnd, rxSetup, setupToken, txRd, txDone, txPipe;
	logic [7:0] awaddr, araddr, rxByte, txData;
	logic [31:0] wdata, rdata, v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, engineBusy, txPending, r;
	logic [1:0][3:0] txLen;
	int mismatches, samples_checked;
	ufa_if i_ufa_if ();
	ufa_device i_ufa_device (.clk_sys, .srst, .port(i_ufa_if), .engineBusy,
		.rxByteValid, .rxPipe, .rxByte, .rxEnd, .rxSetup, .setupToken,
		.txRd, .txDone, .txPipe, .txPending, .txLen, .txData, .txLast);
	ufa_ctl i_ufa_ctl (.clk_sys, .srst, .port(i_ufa_if), .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	ufa_chk i_ufa_chk (.clk_sys, .srst, .regAddr(i_ufa_if.regAddr),
		.regWdata(i_ufa_if.regWdata), .regRdata(i_ufa_if.regRdata),
		.regWr(i_ufa_if.regWr), .regRd(i_ufa_if.regRd),
		.usbInt(i_ufa_if.usbInt), .activePipe(i_ufa_if.activePipe));
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic ha, hw, hb;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		hb = 1'b0;
		while (!hb)
		begin
			@(negedge clk_sys);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid;
			r = bresp;
			@(posedge clk_sys);
			if (ha)
				awvalid <= 1'b0;
			if (hw)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask : axw
	task automatic axr(input logic [7:0] a);
		logic ha, hr;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		hr = 1'b0;
		while (!hr)
		begin
			@(negedge clk_sys);
			ha = arvalid && arready;
			hr = rvalid;
			v = rdata;
			r = rresp;
			@(posedge clk_sys);
			if (ha)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask : axr
	// Polls the status word until the controller is no longer busy
	task automatic idle();
		int k;
		k = 0;
		v = 32'h1;
		while (v[0] !== 1'b0 && k < 600)
		begin
			repeat (20) @(posedge clk_sys);
			axr(AX_STAT);
			k++;
		end
		chk("busy", 32'h0, v[0]);
	endtask : idle
	task automatic rx(input logic p, input int n, input logic s);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_sys);
			rxPipe <= p;
			rxByte <= 8'hA0 + 8'(i);
			rxByteValid <= 1'b1;
			@(posedge clk_sys);
			rxByteValid <= 1'b0;
		end
		@(posedge clk_sys);
		rxPipe <= p;
		rxSetup <= s;
		rxEnd <= 1'b1;
		@(posedge clk_sys);
		rxEnd <= 1'b0;
		rxSetup <= 1'b0;
	endtask : rx
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial
	begin
		#200000;
		mismatches++;
		give_verdict();
	end
	initial
	begin
		{srst, awvalid, wvalid, bready, arvalid, rready} = 6'h21;
		{rxByteValid, rxPipe, rxEnd, rxSetup, setupToken} = 5'h00;
		{txRd, txDone, txPipe} = 3'h0;
		{awaddr, araddr, rxByte, wdata, engineBusy} = 58'h0;
		wstrb = 4'hF;
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		axr(AX_CTRL);
		chk("ctrl", 32'h0, v);
		chk("rresp", RESP_OKAY, r);
		axr(AX_STAT);
		chk("stat", 32'h0, v);
		axr(8'h20);
		chk("rresp", RESP_SLVERR, r);
		chk("rdata", 32'h0, v);
		axw(8'h20, 32'h1);
		chk("bresp", RESP_SLVERR, r);
		$display("test reset done");
		rx(1'b0, 3, 1'b0);
		axw(AX_CTRL, 32'h1);
		idle();
		chk("rx count", 32'h3, v[7:4]);
		axr(AX_RXLO);
		chk("rx bytes", 32'h00A2A1A0, v);
		$display("test read done");
		axw(AX_TXLO, 32'h53525150);
		axw(AX_TXHI, 32'h57565554);
		chk("bresp", RESP_OKAY, r);
		axr(AX_TXHI);
		chk("tx high", 32'h57565554, v);
		axw(AX_CTRL, 32'h807);
		idle();
		chk("tx count", 32'h8, v[7:4]);
		chk("pending", 32'h2, txPending);
		chk("length", 32'h8, txLen[1]);
		txPipe <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk_sys);
			txRd <= 1'b1;
			@(posedge clk_sys);
			txRd <= 1'b0;
			@(negedge clk_sys);
			chk("txData", 32'h50 + i, txData);
			chk("txLast", i == 7, txLast);
		end
		@(posedge clk_sys);
		txDone <= 1'b1;
		@(posedge clk_sys);
		txDone <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("pending", 32'h0, txPending);
		axr(AX_STAT);
		chk("pipe", 32'h1, v[8]);
		$display("test write done");
		engineBusy <= 2'b01;
		axw(AX_CTRL, 32'h3);
		repeat (1000) @(posedge clk_sys);
		axr(AX_STAT);
		chk("held", 32'h1, v[0]);
		chk("pending", 32'h0, txPending);
		engineBusy <= 2'b00;
		idle();
		chk("pending", 32'h1, txPending);
		chk("length", 32'h0, txLen[0]);
		axw(AX_CTRL, 32'h9);
		idle();
		chk("cleared", 32'h0, txPending);
		$display("test zero length and clear done");
		rx(1'b0, 0, 1'b1);
		axw(AX_CTRL, 32'h1);
		idle();
		chk("setup", 32'h1, v[2]);
		chk("zero", 32'h1, v[3]);
		axw(AX_CTRL, 32'h13);
		idle();
		chk("setup", 32'h0, v[2]);
		chk("zero", 32'h0, v[3]);
		rx(1'b0, 0, 1'b0);
		@(posedge clk_sys);
		setupToken <= 1'b1;
		@(posedge clk_sys);
		setupToken <= 1'b0;
		axw(AX_CTRL, 32'h7);
		idle();
		chk("zero", 32'h0, v[3]);
		chk("pending", 32'h3, txPending);
		$display("test flags done");
		give_verdict();
	end
endmodule : usb_endpoint_fifo_access_tb
`default_nettype wire
